// ### rcss_map.svh
/*
  Constants of the remote calibration and serial status block: timing counts,
  serial framing, report layout and character codes.
  Assumes a 125 MHz device clock; included by its bare name.
*/
// Notes on behaviour
// - Busy contact closed during any calibration
// - Contact open: analyse, poll requests, accept one
// - Requests during calibration are dropped, never queued
// - Request still held at end restarts calibration
// - After last calibration, reopen contact, analyse
// - Four range relays, only active range closed
// - Status report every two seconds when enabled
// - Report order: conc, range, span, disabled, tripped
// - Every report item ends with CR LF
// - Span command plus enter starts span
// - Zero command plus enter starts zero
// - Toggle command inverts status report enable
// - Serial link 2400 baud, 8N1
// - Request input selects mode; release lets it end
`ifndef RCSS_MAP_SVH
`define RCSS_MAP_SVH

`define RCSS_CLK_HZ 125000000
`define RCSS_BAUD 2400
`define RCSS_BIT_CYCLES (`RCSS_CLK_HZ / `RCSS_BAUD)
`define RCSS_REPORT_MS 2000
`define RCSS_REPORT_CYCLES ((`RCSS_CLK_HZ / 1000) * `RCSS_REPORT_MS)
`define RCSS_DATA_BITS 8
`define RCSS_FRAME_BITS 10
`define RCSS_RANGES 4
`define RCSS_REPORT_LEN 5'h18
`define RCSS_STATUS_EN_RST 1'b1

`define RCSS_CHR_CR 8'h0D
`define RCSS_CHR_LF 8'h0A
`define RCSS_CHR_A 8'h61
`define RCSS_CHR_S 8'h73
`define RCSS_CHR_Z 8'h7A
`define RCSS_CHR_T 8'h74
`define RCSS_CHR_0 8'h30
`define RCSS_CHR_1 8'h31
`define RCSS_CHR_RNG 8'h52
`define RCSS_CHR_OFF 8'h44
`define RCSS_CHR_TRIP 8'h41

`endif

// ### rcss_pkg.sv
/*
  Types of the remote calibration and serial status block.
  Assumes rcss_map.svh supplies the numeric constants.
*/
package rcss_pkg;
  typedef logic [7:0] rcss_byte_t;
  typedef enum logic [1:0] {CAL_IDLE, CAL_ZERO, CAL_SPAN} rcss_cal_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rcss_rx_e;
endpackage : rcss_pkg

// ### rcss_uart.sv
/*
  Asynchronous serial transmitter and receiver, 8 data bits, no parity,
  one stop bit, least significant bit first.
  Assumes rx_i is an unsynchronised pin and BIT_CYCLES clocks per bit.
*/
`timescale 1ns/100ps
`include "rcss_map.svh"
module rcss_uart
  import rcss_pkg::*;
#(
  parameter int BIT_CYCLES = `RCSS_BIT_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Transmit side
  input wire logic tx_valid_i,
  input wire rcss_byte_t tx_data_i,
  output logic tx_ready_o,
  output logic tx_o,
  // Receive side
  input wire logic rx_i,
  output logic rx_valid_o,
  output rcss_byte_t rx_data_o
);
  localparam logic [31:0] BIT_LAST = 32'(BIT_CYCLES - 1);
  localparam logic [31:0] HALF_LAST = 32'(BIT_CYCLES / 2);

  logic tx_busy_reg, tx_busy_next;
  logic [9:0] tx_shift_reg, tx_shift_next;
  logic [3:0] tx_bits_reg, tx_bits_next;
  logic [31:0] tx_cnt_reg, tx_cnt_next;
  logic rx_meta_reg, rx_sync_reg;
  rcss_rx_e rx_state_reg, rx_state_next;
  logic [31:0] rx_cnt_reg, rx_cnt_next;
  logic [3:0] rx_bits_reg, rx_bits_next;
  rcss_byte_t rx_shift_reg, rx_shift_next;
  logic rx_valid_reg, rx_valid_next;

  assign tx_ready_o = ~tx_busy_reg;
  assign tx_o = tx_shift_reg[0];
  assign rx_valid_o = rx_valid_reg;
  assign rx_data_o = rx_shift_reg;

  // Transmit: start bit low, data LSB first, stop bit high
  always_comb begin
    tx_busy_next = tx_busy_reg;
    tx_shift_next = tx_shift_reg;
    tx_bits_next = tx_bits_reg;
    tx_cnt_next = tx_cnt_reg;
    if (!tx_busy_reg) begin
      if (tx_valid_i) begin
        tx_busy_next = 1'b1;
        tx_shift_next = {1'b1, tx_data_i, 1'b0};
        tx_bits_next = 4'h0;
        tx_cnt_next = 32'h0;
      end
    end else if (tx_cnt_reg == BIT_LAST) begin
      tx_cnt_next = 32'h0;
      tx_shift_next = {1'b1, tx_shift_reg[9:1]};
      if (tx_bits_reg == 4'(`RCSS_FRAME_BITS - 1)) begin
        tx_busy_next = 1'b0;
      end else begin
        tx_bits_next = tx_bits_reg + 4'h1;
      end
    end else begin
      tx_cnt_next = tx_cnt_reg + 32'h1;
    end
  end

  // Receive: confirm start at mid bit, then sample each bit at its middle
  always_comb begin
    rx_state_next = rx_state_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_bits_next = rx_bits_reg;
    rx_shift_next = rx_shift_reg;
    rx_valid_next = 1'b0;
    case (rx_state_reg)
      RX_IDLE: begin
        rx_cnt_next = 32'h0;
        if (!rx_sync_reg) begin
          rx_state_next = RX_START;
        end
      end
      RX_START: begin
        if (rx_cnt_reg == HALF_LAST) begin
          rx_cnt_next = 32'h0;
          rx_bits_next = 4'h0;
          // A glitch shorter than half a bit is not a start bit
          rx_state_next = rx_sync_reg ? RX_IDLE : RX_DATA;
        end else begin
          rx_cnt_next = rx_cnt_reg + 32'h1;
        end
      end
      RX_DATA: begin
        if (rx_cnt_reg == BIT_LAST) begin
          rx_cnt_next = 32'h0;
          rx_shift_next = {rx_sync_reg, rx_shift_reg[7:1]};
          if (rx_bits_reg == 4'(`RCSS_DATA_BITS - 1)) begin
            rx_state_next = RX_STOP;
          end else begin
            rx_bits_next = rx_bits_reg + 4'h1;
          end
        end else begin
          rx_cnt_next = rx_cnt_reg + 32'h1;
        end
      end
      RX_STOP: begin
        if (rx_cnt_reg == BIT_LAST) begin
          rx_valid_next = rx_sync_reg; // Framing error drops the byte
          rx_state_next = RX_IDLE;
        end else begin
          rx_cnt_next = rx_cnt_reg + 32'h1;
        end
      end
      default: begin
        rx_state_next = RX_IDLE;
      end
    endcase
  end

  // Registers of both directions; the line idles high
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_busy_reg <= 1'b0;
      tx_shift_reg <= 10'h3FF;
      tx_bits_reg <= 4'h0;
      tx_cnt_reg <= 32'h0;
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= 32'h0;
      rx_bits_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
    end else begin
      tx_busy_reg <= tx_busy_next;
      tx_shift_reg <= tx_shift_next;
      tx_bits_reg <= tx_bits_next;
      tx_cnt_reg <= tx_cnt_next;
      rx_meta_reg <= rx_i;
      rx_sync_reg <= rx_meta_reg;
      rx_state_reg <= rx_state_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bits_reg <= rx_bits_next;
      rx_shift_reg <= rx_shift_next;
      rx_valid_reg <= rx_valid_next;
    end
  end
endmodule : rcss_uart

// ### rcss_remote_cal.sv
/*
  Remote calibration handshake, range indicator relays and serial status
  reporting with a three-command text interpreter.
  Assumes the analysis engine pulses cal_done_i at the end of a calibration
  and supplies the measurement values on the device clock.
*/
`timescale 1ns/100ps
`include "rcss_map.svh"
module rcss_remote_cal
  import rcss_pkg::*;
#(
  parameter int BIT_CYCLES = `RCSS_BIT_CYCLES,
  parameter int REPORT_CYCLES = `RCSS_REPORT_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Remote calibration pins, asynchronous
  input wire logic zero_req_i,
  input wire logic span_req_i,
  // Calibration engine
  input wire logic cal_done_i,
  output logic cal_busy_o,
  output logic cal_zero_o,
  output logic cal_span_o,
  // Measurement values for the report
  input wire logic [1:0] range_sel_i,
  input wire logic [7:0] conc_pct_i,
  input wire logic [7:0] span_pct_i,
  input wire logic [1:0] alarm_off_report_i,
  input wire logic [1:0] alarm_tripped_report_i,
  // Relays and status
  output logic [`RCSS_RANGES-1:0] range_indicator_relay_o,
  output logic status_en_o,
  // Serial port
  input wire logic rx_i,
  output logic tx_o
);
  localparam logic [31:0] REPORT_LAST = 32'(REPORT_CYCLES - 1);

  logic zreq_meta_reg, zreq_sync_reg, sreq_meta_reg, sreq_sync_reg;
  rcss_cal_e cal_state_reg, cal_state_next;
  rcss_byte_t c0_reg, c0_next, c1_reg, c1_next;
  logic [1:0] len_reg, len_next;
  logic status_en_reg, status_en_next;
  logic [`RCSS_RANGES-1:0] relay_reg, relay_next;
  logic [31:0] timer_reg, timer_next;
  logic sending_reg, sending_next;
  logic [4:0] idx_reg, idx_next;
  logic [7:0] conc_snap_reg, conc_snap_next, span_snap_reg, span_snap_next;
  logic [1:0] rng_snap_reg, rng_snap_next;
  logic [1:0] off_snap_reg, off_snap_next, trip_snap_reg, trip_snap_next;
  logic rx_valid;
  rcss_byte_t rx_data;
  logic tx_ready, tx_valid;
  rcss_byte_t tx_data;
  logic cmd_end, span_cmd, zero_cmd, toggle_cmd;

  rcss_uart #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_uart (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .tx_valid_i(tx_valid),
    .tx_data_i(tx_data),
    .tx_ready_o(tx_ready),
    .tx_o(tx_o),
    .rx_i(rx_i),
    .rx_valid_o(rx_valid),
    .rx_data_o(rx_data)
  );

  // Command decode: exactly two characters followed by the enter terminator
  assign cmd_end = rx_valid && (rx_data == `RCSS_CHR_CR) && (len_reg == 2'h2);
  assign span_cmd = cmd_end && (c1_reg == `RCSS_CHR_A) && (c0_reg == `RCSS_CHR_S);
  assign zero_cmd = cmd_end && (c1_reg == `RCSS_CHR_A) && (c0_reg == `RCSS_CHR_Z);
  assign toggle_cmd = cmd_end && (c1_reg == `RCSS_CHR_S) && (c0_reg == `RCSS_CHR_T);

  // Character history; a line feed after enter is ignored
  always_comb begin
    c0_next = c0_reg;
    c1_next = c1_reg;
    len_next = len_reg;
    if (rx_valid) begin
      if (rx_data == `RCSS_CHR_CR) begin
        len_next = 2'h0;
      end else if (rx_data != `RCSS_CHR_LF) begin
        c1_next = c0_reg;
        c0_next = rx_data;
        len_next = (len_reg == 2'h3) ? 2'h3 : len_reg + 2'h1;
      end
    end
  end

  // Calibration sequencer; commands and pins are only heard while idle
  always_comb begin
    cal_state_next = cal_state_reg;
    case (cal_state_reg)
      CAL_IDLE: begin
        // Contact open: requests polled and taken; zero wins a tie
        if (zreq_sync_reg || zero_cmd) begin
          cal_state_next = CAL_ZERO;
        end else if (sreq_sync_reg || span_cmd) begin
          cal_state_next = CAL_SPAN;
        end
      end
      CAL_ZERO, CAL_SPAN: begin
        // New requests are not looked at here, so none is remembered
        // Back to idle; a still-held request restarts it next cycle
        if (cal_done_i) begin
          cal_state_next = CAL_IDLE;
        end
      end
      default: begin
        cal_state_next = CAL_IDLE;
      end
    endcase
  end

  // Contact and mode outputs follow the sequencer state directly
  assign cal_busy_o = (cal_state_reg != CAL_IDLE);
  assign cal_zero_o = (cal_state_reg == CAL_ZERO);
  assign cal_span_o = (cal_state_reg == CAL_SPAN);
  assign status_en_o = status_en_reg;
  assign range_indicator_relay_o = relay_reg;

  // One relay per range in ascending order, only the active one closed
  generate
    for (genvar g = 0; g < `RCSS_RANGES; g++) begin : g_relay
      assign relay_next[g] = (range_sel_i == 2'(g));
    end
  endgenerate

  // Report enable toggles on each toggle command and holds otherwise
  assign status_en_next = toggle_cmd ? ~status_en_reg : status_en_reg;

  // ASCII digit of a value below ten
  function automatic rcss_byte_t rcss_digit(input logic [7:0] v);
    rcss_digit = `RCSS_CHR_0 + v;
  endfunction : rcss_digit

  // Byte of the report at a position; each item closes with CR LF
  function automatic rcss_byte_t rcss_report_byte(input logic [4:0] i,
      input logic [7:0] conc, input logic [1:0] rng, input logic [7:0] span,
      input logic [1:0] off, input logic [1:0] trip);
    case (i)
      5'h00: rcss_report_byte = rcss_digit(conc / 8'h64);
      5'h01: rcss_report_byte = rcss_digit((conc / 8'h0A) % 8'h0A);
      5'h02: rcss_report_byte = rcss_digit(conc % 8'h0A);
      5'h05: rcss_report_byte = `RCSS_CHR_RNG;
      5'h06: rcss_report_byte = `RCSS_CHR_1 + {6'h00, rng};
      5'h09: rcss_report_byte = rcss_digit(span / 8'h64);
      5'h0A: rcss_report_byte = rcss_digit((span / 8'h0A) % 8'h0A);
      5'h0B: rcss_report_byte = rcss_digit(span % 8'h0A);
      5'h0E: rcss_report_byte = `RCSS_CHR_OFF;
      5'h0F: rcss_report_byte = rcss_digit({7'h00, off[1]});
      5'h10: rcss_report_byte = rcss_digit({7'h00, off[0]});
      5'h13: rcss_report_byte = `RCSS_CHR_TRIP;
      5'h14: rcss_report_byte = rcss_digit({7'h00, trip[1]});
      5'h15: rcss_report_byte = rcss_digit({7'h00, trip[0]});
      5'h03, 5'h07, 5'h0C, 5'h11, 5'h16: rcss_report_byte = `RCSS_CHR_CR;
      default: rcss_report_byte = `RCSS_CHR_LF;
    endcase
  endfunction : rcss_report_byte

  // Report bytes are offered to the transmitter while a report is running
  assign tx_valid = sending_reg;
  assign tx_data = rcss_report_byte(idx_reg, conc_snap_reg, rng_snap_reg, span_snap_reg,
                                    off_snap_reg, trip_snap_reg);

  // Two-second period timer and report sequencer; values are frozen at the
  // start so that one report never mixes two measurements
  always_comb begin
    timer_next = (timer_reg == REPORT_LAST) ? 32'h0 : timer_reg + 32'h1;
    sending_next = sending_reg;
    idx_next = idx_reg;
    conc_snap_next = conc_snap_reg;
    rng_snap_next = rng_snap_reg;
    span_snap_next = span_snap_reg;
    off_snap_next = off_snap_reg;
    trip_snap_next = trip_snap_reg;
    if (!sending_reg) begin
      // A report still running at the tick is not restarted; at 2400 baud
      // one report takes about 0.1 s, far inside the period
      if ((timer_reg == REPORT_LAST) && status_en_reg) begin
        sending_next = 1'b1;
        idx_next = 5'h00;
        conc_snap_next = conc_pct_i;
        rng_snap_next = range_sel_i;
        span_snap_next = span_pct_i;
        off_snap_next = alarm_off_report_i;
        trip_snap_next = alarm_tripped_report_i;
      end
    end else if (tx_ready) begin
      if (idx_reg == `RCSS_REPORT_LEN - 5'h01) begin
        sending_next = 1'b0;
      end else begin
        idx_next = idx_reg + 5'h01;
      end
    end
  end

  // State registers; request pins pass two flip-flops first
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      zreq_meta_reg <= 1'b0;
      zreq_sync_reg <= 1'b0;
      sreq_meta_reg <= 1'b0;
      sreq_sync_reg <= 1'b0;
      cal_state_reg <= CAL_IDLE;
      c0_reg <= 8'h00;
      c1_reg <= 8'h00;
      len_reg <= 2'h0;
      status_en_reg <= `RCSS_STATUS_EN_RST;
      relay_reg <= '0;
      timer_reg <= 32'h0;
      sending_reg <= 1'b0;
      idx_reg <= 5'h00;
      conc_snap_reg <= 8'h00;
      rng_snap_reg <= 2'h0;
      span_snap_reg <= 8'h00;
      off_snap_reg <= 2'h0;
      trip_snap_reg <= 2'h0;
    end else begin
      zreq_meta_reg <= zero_req_i;
      zreq_sync_reg <= zreq_meta_reg;
      sreq_meta_reg <= span_req_i;
      sreq_sync_reg <= sreq_meta_reg;
      cal_state_reg <= cal_state_next;
      c0_reg <= c0_next;
      c1_reg <= c1_next;
      len_reg <= len_next;
      status_en_reg <= status_en_next;
      relay_reg <= relay_next;
      timer_reg <= timer_next;
      sending_reg <= sending_next;
      idx_reg <= idx_next;
      conc_snap_reg <= conc_snap_next;
      rng_snap_reg <= rng_snap_next;
      span_snap_reg <= span_snap_next;
      off_snap_reg <= off_snap_next;
      trip_snap_reg <= trip_snap_next;
    end
  end
endmodule : rcss_remote_cal

// ### rcss_checker.sv
/*
  Port checker for the remote calibration and serial status block.
  Assumes it is bound to every rcss_remote_cal instance with its counts.
*/
`timescale 1ns/100ps
module rcss_checker #(
  parameter int BIT_CYCLES = 8,
  parameter int REPORT_CYCLES = 4000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Calibration handshake
  input wire logic zero_req_i,
  input wire logic span_req_i,
  input wire logic cal_done_i,
  input wire logic cal_busy_o,
  input wire logic cal_zero_o,
  input wire logic cal_span_o,
  // Relays, status and serial out
  input wire logic [1:0] range_sel_i,
  input wire logic [3:0] range_indicator_relay_o,
  input wire logic status_en_o,
  input wire logic tx_o
);
  localparam int HI_LIM = REPORT_CYCLES + 4;
  localparam int OFF_LIM = 26 * 10 * BIT_CYCLES;
  int hi_cnt_reg;
  int hi_cnt_next;
  int off_cnt_reg;
  int off_cnt_next;

  // Idle-line and reports-off counters; the off counter saturates so it cannot wrap
  always_comb begin
    hi_cnt_next = (tx_o && status_en_o) ? hi_cnt_reg + 1 : 0;
    off_cnt_next = status_en_o ? 0 : off_cnt_reg + ((off_cnt_reg > OFF_LIM) ? 0 : 1);
  end

  // Counter registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hi_cnt_reg <= 0;
      off_cnt_reg <= 0;
    end else begin
      hi_cnt_reg <= hi_cnt_next;
      off_cnt_reg <= off_cnt_next;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // Calibration contact and modes
  a_busy_means_cal: assert property (cal_busy_o == (cal_zero_o ^ cal_span_o))
    else $error("busy contact disagrees with calibration mode");
  a_busy_holds: assert property (cal_busy_o && !cal_done_i |=> cal_busy_o)
    else $error("busy contact opened before calibration end");
  a_done_opens: assert property (cal_done_i && cal_busy_o |=> !cal_busy_o)
    else $error("busy contact stayed closed after calibration end");
  a_zero_accept: assert property ((zero_req_i && !cal_busy_o) [*3] |-> ##[1:2] cal_zero_o)
    else $error("zero request not accepted while idle");
  a_span_accept: assert property (
    (span_req_i && !zero_req_i && !cal_busy_o) [*3] |-> ##[1:2] cal_span_o)
    else $error("span request not accepted while idle");
  a_no_queue: assert property (
    (!zero_req_i && !span_req_i) [*3] ##0 cal_done_i |=> !cal_busy_o [*2])
    else $error("calibration started from a dropped request");
  a_held_restart: assert property (cal_done_i && cal_zero_o && zero_req_i
    && $past(zero_req_i) && $past(zero_req_i, 2) |=> !cal_busy_o ##1 cal_zero_o)
    else $error("held zero request did not restart calibration");

  // Relays and status report
  a_relay_range: assert property (1 |=> range_indicator_relay_o == (4'h1 << $past(range_sel_i)))
    else $error("range relay does not match range in use");
  a_report_period: assert property (hi_cnt_reg <= HI_LIM)
    else $error("status report overdue");
  a_quiet_off: assert property (off_cnt_reg > OFF_LIM |-> tx_o)
    else $error("serial output active while reports disabled");

  c_zero: cover property ($rose(cal_zero_o));
  c_span: cover property ($rose(cal_span_o));
  c_off: cover property ($fell(status_en_o));
endmodule : rcss_checker

bind rcss_remote_cal rcss_checker #(.BIT_CYCLES(BIT_CYCLES), .REPORT_CYCLES(REPORT_CYCLES))
  rcss_checker_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .zero_req_i(zero_req_i),
  .span_req_i(span_req_i), .cal_done_i(cal_done_i), .cal_busy_o(cal_busy_o),
  .cal_zero_o(cal_zero_o), .cal_span_o(cal_span_o), .range_sel_i(range_sel_i),
  .range_indicator_relay_o(range_indicator_relay_o), .status_en_o(status_en_o), .tx_o(tx_o));

// ### rcss_term.sv
/*
  Serial terminal model standing on the far side of the status port.
  Assumes 8N1 framing at BIT_CYCLES device clocks per bit, line idle high.
*/
`timescale 1ns/100ps
module rcss_term #(
  parameter int BIT_CYCLES = 8
) (
  // Clock
  input wire logic clk_i,
  // Serial lines
  input wire logic dev_tx_i,
  output logic dev_rx_o
);
  logic [7:0] got[$];
  logic [7:0] shift;

  // Line rests at the mark level between frames
  initial dev_rx_o = 1'b1;

  // One character; caller enters just after a clock edge
  task automatic send(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      dev_rx_o = frame[i];
      repeat (BIT_CYCLES) @(posedge clk_i);
      #1;
    end
  endtask : send

  // Mid-bit sampling keeps clear of the edges where the line moves
  always begin
    @(negedge dev_tx_i);
    repeat (BIT_CYCLES / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clk_i);
      shift[i] = dev_tx_i;
    end
    repeat (BIT_CYCLES) @(posedge clk_i);
    if (dev_tx_i) got.push_back(shift);
  end
endmodule : rcss_term

// ### tb.sv
/*
  Self-checking bench for rcss_remote_cal: pin handshake, text commands,
  range relays and the periodic status report.
  Assumes shortened bit and report counts given below.
*/
`timescale 1ns/100ps
`include "rcss_map.svh"
module tb;
  localparam int BITC = 8;
  localparam int REPC = 4000;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic zero_req = 1'b0;
  logic span_req = 1'b0;
  logic cal_done = 1'b0;
  logic [1:0] range_sel = 2'h0;
  logic [1:0] off = 2'h0;
  logic [1:0] trip = 2'h0;
  logic [7:0] conc = 8'h00;
  logic [7:0] span = 8'h00;
  logic busy, cal_zero, cal_span, status_en, rx, tx;
  logic [3:0] relay;
  logic [7:0] exp_q[$];
  int errors = 0;
  int n_checks = 0;

  rcss_remote_cal #(.BIT_CYCLES(BITC), .REPORT_CYCLES(REPC)) rcss_remote_cal_i (
    .clk_i(clk), .reset_n_i(reset_n), .zero_req_i(zero_req), .span_req_i(span_req),
    .cal_done_i(cal_done), .cal_busy_o(busy), .cal_zero_o(cal_zero), .cal_span_o(cal_span),
    .range_sel_i(range_sel), .conc_pct_i(conc), .span_pct_i(span), .alarm_off_report_i(off),
    .alarm_tripped_report_i(trip), .range_indicator_relay_o(relay), .status_en_o(status_en),
    .rx_i(rx), .tx_o(tx));
  rcss_term #(.BIT_CYCLES(BITC)) rcss_term_i (.clk_i(clk), .dev_tx_i(tx), .dev_rx_o(rx));

  always #4 clk = ~clk;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Bounded wait on the contact
  task automatic wait_busy(input logic want);
    for (int i = 0; i < 300 && busy !== want; i++) step(1);
  endtask : wait_busy

  task automatic finish_cal();
    step($urandom_range(12, 4));
    cal_done = 1'b1;
    step(1);
    cal_done = 1'b0;
    check("busy after done", 0, busy);
  endtask : finish_cal

  // Controller side: request, wait for closure, release
  task automatic pin_cal(input logic is_zero);
    if (is_zero) zero_req = 1'b1; else span_req = 1'b1;
    wait_busy(1'b1);
    check("mode", {is_zero, !is_zero}, {cal_zero, cal_span});
    zero_req = 1'b0;
    span_req = 1'b0;
    finish_cal();
  endtask : pin_cal

  task automatic cmd(input logic [7:0] c1, input logic [7:0] c2);
    rcss_term_i.send(c1);
    rcss_term_i.send(c2);
    rcss_term_i.send(`RCSS_CHR_CR);
    step(2);
  endtask : cmd

  function automatic logic [7:0] d(input logic [7:0] v);
    return `RCSS_CHR_0 + v;
  endfunction : d

  // Expected report from the current inputs
  function automatic void make_report();
    exp_q = {d(conc / 100), d(conc / 10 % 10), d(conc % 10), `RCSS_CHR_CR, `RCSS_CHR_LF,
      `RCSS_CHR_RNG, `RCSS_CHR_1 + range_sel, `RCSS_CHR_CR, `RCSS_CHR_LF,
      d(span / 100), d(span / 10 % 10), d(span % 10), `RCSS_CHR_CR, `RCSS_CHR_LF,
      `RCSS_CHR_OFF, d(off[1]), d(off[0]), `RCSS_CHR_CR, `RCSS_CHR_LF,
      `RCSS_CHR_TRIP, d(trip[1]), d(trip[0]), `RCSS_CHR_CR, `RCSS_CHR_LF};
  endfunction : make_report

  // Waits for an inter-report gap so the capture starts on a whole report
  task automatic check_report();
    int hi;
    hi = 0;
    {conc, span, off, trip, range_sel} = 22'($urandom);
    make_report();
    for (int i = 0; i < 6000 && hi < 200; i++) begin
      step(1);
      hi = (tx === 1'b1) ? hi + 1 : 0;
    end
    rcss_term_i.got = {};
    for (int i = 0; i < 6000 && rcss_term_i.got.size() < 24; i++) step(1);
    check("report length", 24, rcss_term_i.got.size());
    foreach (exp_q[i]) check("report byte", exp_q[i], rcss_term_i.got[i]);
  endtask : check_report

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    void'($urandom(76928));
    step(16);
    check("reset state", 8'h10, {busy, cal_zero, cal_span, status_en, relay});
    reset_n = 1'b1;
    repeat (6) begin
      range_sel = 2'($urandom);
      step(2);
      check("relay", 4'h1 << range_sel, relay);
    end
    pin_cal(1'b1);
    pin_cal(1'b0);
    zero_req = 1'b1;
    wait_busy(1'b1);
    zero_req = 1'b0;
    step(3);
    span_req = 1'b1;
    step(4);
    span_req = 1'b0;
    step(3);
    finish_cal();
    step(4);
    check("dropped request", 0, busy);
    zero_req = 1'b1;
    wait_busy(1'b1);
    step(3);
    finish_cal();
    step(1);
    check("restart", 2'h3, {busy, cal_zero});
    zero_req = 1'b0;
    finish_cal();
    cmd(`RCSS_CHR_A, `RCSS_CHR_Z);
    check("zero command", 2'h2, {cal_zero, cal_span});
    cmd(`RCSS_CHR_A, `RCSS_CHR_S);
    check("command while busy", 2'h2, {cal_zero, cal_span});
    finish_cal();
    step(3);
    check("no stored command", 0, busy);
    cmd(`RCSS_CHR_A, `RCSS_CHR_S);
    check("span command", 2'h1, {cal_zero, cal_span});
    finish_cal();
    cmd(`RCSS_CHR_A, 8'h78);
    check("unknown command", 0, busy);
    check_report();
    cmd(`RCSS_CHR_S, `RCSS_CHR_T);
    check("status off", 0, status_en);
    step(2100);
    rcss_term_i.got = {};
    step(4100);
    check("reports while off", 0, rcss_term_i.got.size());
    cmd(`RCSS_CHR_S, `RCSS_CHR_T);
    check("status on", 1, status_en);
    check_report();
    test_done();
  end

  // Watchdog sized well above the expected run
  initial begin
    #480000;
    errors++;
    test_done();
  end
endmodule : tb
